// ===== rtl/queue_entry_remover.sv
// Function
// RL1: Checked tail: misaligned header raises illegal operand.
// RL2: Reserving load; lock bit set returns -1.
// RL3: Conditional store sets lock; retry until success.
// RL4: Retry count twenty; exhaustion returns -1 untouched.
// RL5: Checked: misaligned backward link releases, faults.
// RL6: Checked: probe all accesses before any change.
// RL7: Entry and predecessor from offsets; predecessor aligned.
// RL8: Quad links: backward at offset 8, 64-bit.
// RL9: Header, predecessor links written; barrier; release. When the predecessor is the header, no predecessor write and no barrier.
// RL10: Tail status 0, 2 or 1, entry returned.
// RL11: Resident tail skips every precheck.
// RL12: Whole removal uninterrupted and atomic.
// RL13: Long removal: direct or deferred sign-extended address.
// RL14: Long removal: 32-bit links, backward at 4.
// RL15: Absolute status -1, 0 or 1, entry returned.
// RL16: Quad absolute: four addresses must be aligned.
// RL17: On quad absolute exception results undefined.
// RL18: One-cycle done pulse after results, or exception.
`timescale 1ns/1ps
`include "qer_cfg.svh"
module queue_entry_remover
(
  input  wire logic            i_ref_clk,
  input  wire logic            i_reset,
  input  wire logic            i_start,
  input  wire qer_pkg::op_type i_op,
  input  wire logic [63:0]     i_argument_register,
  output logic                 o_busy_ff,
  output logic                 o_done_ff,
  output qer_pkg::exc_type     o_exc_ff,
  output logic [63:0]          o_status_result_register_ff,
  output logic [63:0]          o_entry_result_register_ff,
  output logic                 o_mem_req_ff,
  output qer_pkg::mem_cmd_type o_mem_cmd_ff,
  output logic [63:0]          o_mem_addr_ff,
  output logic [63:0]          o_mem_wdata_ff,
  output logic                 o_mem_long_ff,
  output logic                 o_mem_probe_ff,
  output logic                 o_mem_barrier_ff,
  input  wire logic            i_mem_ack,
  input  wire logic [63:0]     i_mem_rdata,
  input  wire logic            i_mem_ok
);
  typedef enum logic [4:0] {
    st_idle    = 5'h00, st_lock  = 5'h01, st_cond  = 5'h02, st_mb1   = 5'h03,
    st_rdblink = 5'h04, st_chk   = 5'h05, st_rdpred = 5'h06, st_probe = 5'h07,
    st_wrhb    = 5'h08, st_wrpf  = 5'h09, st_mb2   = 5'h0a, st_release = 5'h0b,
    st_defer   = 5'h0c, st_rdf   = 5'h0d, st_rdb   = 5'h0e, st_abprobe = 5'h0f,
    st_wrpred  = 5'h10, st_wrsucc = 5'h11, st_fin  = 5'h12, st_fail_rel = 5'h13
  } state_type;

  qer_mem_if mif ();

  state_type            state_ff;
  qer_pkg::op_type      op_ff;
  qer_pkg::exc_type     exc_ff;
  logic [4:0]           retry_ff;
  logic [1:0]           probe_ff;
  logic [63:0]          arg_ff, tmp0_ff, tmp5_ff, pred_ff, fwd_ff, ent_ff;

  // Decoded views of the current operation and the probe plan.
  wire         is_tail     = (op_ff == qer_pkg::op_tail_locked) |
                             (op_ff == qer_pkg::op_tail_locked_resident);
  wire         is_checked  = (op_ff == qer_pkg::op_tail_locked);
  wire         is_long     = (op_ff == qer_pkg::op_long_abs) |
                             (op_ff == qer_pkg::op_long_abs_deferred);
  wire         is_deferred = (op_ff == qer_pkg::op_long_abs_deferred) |
                             (op_ff == qer_pkg::op_quad_abs_deferred);
  wire [63:0]  blink_ofs   = is_long ? `QER_BLINK_OFS_L : `QER_BLINK_OFS_Q;
  wire [63:0]  rd_sext     = is_long ? {{32{i_mem_rdata[31]}}, i_mem_rdata[31:0]}
                                     : i_mem_rdata;
  wire [63:0]  entry_addr  = arg_ff + tmp5_ff;
  wire [63:0]  hdr_fwd     = {tmp0_ff[63:1], 1'b0};
  wire         mis_arg     = |arg_ff[`QER_ALIGN_MSB:0];
  wire         mis_rd      = |i_mem_rdata[`QER_ALIGN_MSB:0];
  wire         quad_abs    = ~is_tail & ~is_long;
  wire         pred_is_hdr = (pred_ff == arg_ff);
  wire [63:0]  tail_status = (hdr_fwd == 64'h0) ? `QER_ST_WAS_EMPTY :
                             pred_is_hdr ? `QER_ST_NOW_EMPTY : `QER_ST_NOT_EMPTY;
  wire [63:0]  abs_status  = (ent_ff == pred_ff) ? `QER_AB_WAS_EMPTY :
                             (fwd_ff == pred_ff) ? `QER_AB_NOW_EMPTY
                                                 : `QER_AB_NOT_EMPTY;
  wire [63:0]  tail_probe_a = (probe_ff == 2'h0) ? entry_addr + blink_ofs :
                              (probe_ff == 2'h1) ? arg_ff : pred_ff;
  wire [63:0]  abs_probe_a  = (probe_ff == 2'h0) ? pred_ff :
                              (probe_ff == 2'h1) ? fwd_ff + blink_ofs : ent_ff;
  wire         md          = mif.done;

  // Memory step request; it rises for one cycle per step and the port then holds it.
  always_comb
  begin
    mif.req     = ~o_mem_req_ff;
    mif.cmd     = qer_pkg::mem_read;
    mif.addr    = arg_ff;
    mif.wdata   = 64'h0;
    mif.long    = is_long;
    mif.probe   = 1'b0;
    mif.barrier = 1'b0;
    unique case (state_ff)
      // RL2 reserving load of header
      st_lock:     mif.cmd = qer_pkg::mem_locked;
      // RL3 conditional lock store
      st_cond:     begin mif.cmd = qer_pkg::mem_cond; mif.wdata = tmp0_ff | 64'h1; end
      st_mb1, st_mb2: mif.barrier = 1'b1;
      // RL8 backward link at offset 8
      st_rdblink:  mif.addr = arg_ff + blink_ofs;
      st_rdpred:   mif.addr = entry_addr + blink_ofs;
      // RL6 probe without modification
      st_probe:    begin mif.probe = 1'b1; mif.addr = tail_probe_a;
                         mif.cmd = probe_ff == 2'h0 ? qer_pkg::mem_read : qer_pkg::mem_write; end
      st_abprobe:  begin mif.probe = 1'b1;
                         mif.cmd = qer_pkg::mem_write; mif.addr = abs_probe_a; end
      // RL9 header backward link
      st_wrhb:     begin mif.cmd = qer_pkg::mem_write;
                         mif.addr = arg_ff + blink_ofs; mif.wdata = pred_ff - arg_ff; end
      st_wrpf:     begin mif.cmd = qer_pkg::mem_write;
                         mif.addr = pred_ff; mif.wdata = arg_ff - pred_ff; end
      st_release:  begin mif.cmd = qer_pkg::mem_write;
                         mif.wdata = pred_is_hdr ? 64'h0 : hdr_fwd; end
      st_fail_rel: begin mif.cmd = qer_pkg::mem_write; mif.wdata = tmp0_ff; end
      // RL13 deferred pointer fetch
      st_defer:    mif.addr = arg_ff;
      st_rdf:      mif.addr = ent_ff;
      st_rdb:      mif.addr = ent_ff + blink_ofs;
      // RL14 unlink predecessor then successor
      st_wrpred:   begin mif.cmd = qer_pkg::mem_write;
                         mif.addr = pred_ff; mif.wdata = fwd_ff; end
      st_wrsucc:   begin mif.cmd = qer_pkg::mem_write;
                         mif.addr = fwd_ff + blink_ofs; mif.wdata = pred_ff; end
      default:     mif.req = 1'b0;
    endcase
  end

  qer_mem_port u_port
  (
    .i_ref_clk    (i_ref_clk),
    .i_reset      (i_reset),
    .mif          (mif.port),
    .o_req_ff     (o_mem_req_ff),
    .o_cmd_ff     (o_mem_cmd_ff),
    .o_addr_ff    (o_mem_addr_ff),
    .o_wdata_ff   (o_mem_wdata_ff),
    .o_long_ff    (o_mem_long_ff),
    .o_probe_ff   (o_mem_probe_ff),
    .o_barrier_ff (o_mem_barrier_ff),
    .i_ack        (i_mem_ack),
    .i_rdata      (i_mem_rdata),
    .i_ok         (i_mem_ok)
  );

  // Sequencer. It never accepts a new start until the current one ends, so a
  // removal runs to completion with no interruption.
  // RL12 uninterrupted sequence
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      state_ff <= st_idle;
      op_ff <= qer_pkg::op_tail_locked;
      exc_ff <= qer_pkg::exc_none;
      retry_ff <= 5'h0;
      probe_ff <= 2'h0;
      arg_ff <= 64'h0; // Link scratch registers are loaded before use.
      o_busy_ff <= 1'b0;
      o_done_ff <= 1'b0;
      o_exc_ff <= qer_pkg::exc_none;
      o_status_result_register_ff <= 64'h0;
      o_entry_result_register_ff <= 64'h0;
    end
    else
    begin
      o_done_ff <= 1'b0;
      case (state_ff)
        st_idle:
          if (i_start)
          begin
            op_ff <= i_op;
            arg_ff <= i_argument_register;
            // RL4 retry start twenty
            retry_ff <= `QER_RETRY_INIT;
            probe_ff <= 2'h0;
            exc_ff <= qer_pkg::exc_none;
            o_busy_ff <= 1'b1;
            state_ff <= st_chk;
          end
        st_chk:
          // RL1 header alignment check
          if (is_checked & mis_arg)
          begin exc_ff <= qer_pkg::exc_illegal; state_ff <= st_fin; end
          // RL11 resident skips checks
          else if (is_tail) state_ff <= st_lock;
          // RL16 pointer or entry alignment
          else if (quad_abs & mis_arg)
          begin exc_ff <= qer_pkg::exc_illegal; state_ff <= st_fin; end
          else if (is_deferred) state_ff <= st_defer;
          else
          begin
            ent_ff <= is_long ? {{32{arg_ff[31]}}, arg_ff[31:0]} : arg_ff;
            state_ff <= st_rdf;
          end
        st_lock:
          if (md)
          begin
            tmp0_ff <= i_mem_rdata;
            if (i_mem_rdata[`QER_LOCK_BIT])
            begin
              o_status_result_register_ff <= `QER_ST_BUSY;
              state_ff <= st_fin;
            end
            else state_ff <= st_cond;
          end
        st_cond:
          if (md)
          begin
            // RL4 exhausted retries
            if (i_mem_ok) state_ff <= st_mb1;
            else if (retry_ff == 5'h1)
            begin
              o_status_result_register_ff <= `QER_ST_BUSY;
              state_ff <= st_fin;
            end
            else state_ff <= st_lock;
            retry_ff <= retry_ff - 5'h1;
          end
        st_mb1: if (md) state_ff <= st_rdblink;
        st_rdblink:
          if (md)
          begin
            tmp5_ff <= i_mem_rdata;
            // RL5 backward link alignment
            if (is_checked & mis_rd)
            begin exc_ff <= qer_pkg::exc_illegal; state_ff <= st_fail_rel; end
            else state_ff <= st_rdpred;
          end
        st_rdpred:
          if (md)
          begin
            // RL7 predecessor address
            pred_ff <= entry_addr + i_mem_rdata;
            state_ff <= is_checked ? st_probe : st_wrhb;
          end
        st_probe:
          if (md)
          begin
            // RL6 failed probe releases
            if (~mif.ok)
            begin exc_ff <= qer_pkg::exc_memmgt; state_ff <= st_fail_rel; end
            else if (probe_ff == 2'h2)
            begin
              probe_ff <= 2'h0;
              // RL7 predecessor alignment
              if (|pred_ff[`QER_ALIGN_MSB:0])
              begin exc_ff <= qer_pkg::exc_illegal; state_ff <= st_fail_rel; end
              else state_ff <= st_wrhb;
            end
            else probe_ff <= probe_ff + 2'h1;
          end
        st_wrhb: if (md) state_ff <= pred_is_hdr ? st_release : st_wrpf;
        st_wrpf: if (md) state_ff <= st_mb2;
        // RL9 barrier before release
        st_mb2:  if (md) state_ff <= st_release;
        st_release:
          if (md)
          begin
            // RL10 tail status
            o_status_result_register_ff <= tail_status;
            o_entry_result_register_ff <= entry_addr;
            state_ff <= st_fin;
          end
        st_fail_rel: if (md) state_ff <= st_fin;
        st_defer:
          if (md)
          begin
            ent_ff <= rd_sext;
            if (quad_abs & mis_rd)
            begin exc_ff <= qer_pkg::exc_illegal; state_ff <= st_fin; end
            else state_ff <= st_rdf;
          end
        st_rdf:
          if (md)
          begin
            fwd_ff <= rd_sext;
            if (quad_abs & (mis_rd | (|ent_ff[`QER_ALIGN_MSB:0])))
            begin exc_ff <= qer_pkg::exc_illegal; state_ff <= st_fin; end
            else state_ff <= st_rdb;
          end
        st_rdb:
          if (md)
          begin
            pred_ff <= rd_sext;
            if (quad_abs & mis_rd)
            begin exc_ff <= qer_pkg::exc_illegal; state_ff <= st_fin; end
            else state_ff <= st_abprobe;
          end
        st_abprobe:
          if (md)
          begin
            if (~mif.ok)
            begin exc_ff <= qer_pkg::exc_memmgt; state_ff <= st_fin; end
            else if (probe_ff == 2'h1)
            begin probe_ff <= 2'h0; state_ff <= st_wrpred; end
            else probe_ff <= probe_ff + 2'h1;
          end
        st_wrpred: if (md) state_ff <= st_wrsucc;
        st_wrsucc:
          if (md)
          begin
            // RL15 absolute status
            o_status_result_register_ff <= abs_status;
            o_entry_result_register_ff <= ent_ff;
            state_ff <= st_fin;
          end
        st_fin:
          begin
            // RL18 done pulse
            // RL17 results left unchanged on exception
            o_done_ff <= 1'b1;
            o_exc_ff <= exc_ff;
            o_busy_ff <= 1'b0;
            state_ff <= st_idle;
          end
        default: state_ff <= st_idle;
      endcase
    end
  end
endmodule

// ===== rtl/qer_cfg.svh
`ifndef QER_CFG_SVH
`define QER_CFG_SVH
`define QER_RETRY_INIT     5'h14
`define QER_BLINK_OFS_Q    64'h0000_0000_0000_0008
`define QER_BLINK_OFS_L    64'h0000_0000_0000_0004
`define QER_ALIGN_MSB      3
`define QER_LOCK_BIT       0
`define QER_ST_BUSY        64'hffff_ffff_ffff_ffff
`define QER_ST_WAS_EMPTY   64'h0000_0000_0000_0000
`define QER_ST_NOT_EMPTY   64'h0000_0000_0000_0001
`define QER_ST_NOW_EMPTY   64'h0000_0000_0000_0002
`define QER_AB_WAS_EMPTY   64'hffff_ffff_ffff_ffff
`define QER_AB_NOW_EMPTY   64'h0000_0000_0000_0000
`define QER_AB_NOT_EMPTY   64'h0000_0000_0000_0001
`endif

// ===== rtl/qer_pkg.sv
package qer_pkg;
  typedef enum logic [2:0] {
    op_tail_locked          = 3'h0,
    op_tail_locked_resident = 3'h1,
    op_long_abs             = 3'h2,
    op_long_abs_deferred    = 3'h3,
    op_quad_abs             = 3'h4,
    op_quad_abs_deferred    = 3'h5
  } op_type;
  typedef enum logic [1:0] {
    exc_none    = 2'h0,
    exc_illegal = 2'h1,
    exc_memmgt  = 2'h2
  } exc_type;
  typedef enum logic [1:0] {
    mem_read   = 2'h0,
    mem_locked = 2'h1,
    mem_cond   = 2'h2,
    mem_write  = 2'h3
  } mem_cmd_type;
endpackage

// ===== rtl/qer_mem_if.sv
`timescale 1ns/1ps
// Memory request channel between the sequencer and the port adapter.
interface qer_mem_if;
  logic                 req;
  qer_pkg::mem_cmd_type cmd;
  logic [63:0]          addr;
  logic [63:0]          wdata;
  logic                 long;
  logic                 probe;
  logic                 barrier;
  logic                 done;
  logic [63:0]          rdata;
  logic                 ok;
  modport seq (output req, cmd, addr, wdata, long, probe, barrier,
               input done, rdata, ok);
  modport port (input req, cmd, addr, wdata, long, probe, barrier,
                output done, rdata, ok);
endinterface

// ===== rtl/qer_mem_port.sv
`timescale 1ns/1ps
`include "qer_cfg.svh"
// Holds one memory request on registered pins until the memory answers.
module qer_mem_port
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_reset,
  qer_mem_if.port           mif,
  output logic              o_req_ff,
  output qer_pkg::mem_cmd_type o_cmd_ff,
  output logic [63:0]       o_addr_ff,
  output logic [63:0]       o_wdata_ff,
  output logic              o_long_ff,
  output logic              o_probe_ff,
  output logic              o_barrier_ff,
  input  wire logic         i_ack,
  input  wire logic [63:0]  i_rdata,
  input  wire logic         i_ok
);
  // Request stays up until acknowledged; a barrier also waits for its ack.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_req_ff     <= 1'b0;
      o_cmd_ff     <= qer_pkg::mem_read;
      o_addr_ff    <= 64'h0;
      o_wdata_ff   <= 64'h0;
      o_long_ff    <= 1'b0;
      o_probe_ff   <= 1'b0;
      o_barrier_ff <= 1'b0;
    end
    else if (o_req_ff)
    begin
      if (i_ack)
        o_req_ff <= 1'b0;
    end
    else if (mif.req)
    begin
      o_req_ff     <= 1'b1;
      o_cmd_ff     <= mif.cmd;
      o_addr_ff    <= mif.addr;
      o_wdata_ff   <= mif.wdata;
      o_long_ff    <= mif.long;
      o_probe_ff   <= mif.probe;
      o_barrier_ff <= mif.barrier;
    end
  end
  assign mif.done  = o_req_ff & i_ack;
  assign mif.rdata = i_rdata;
  assign mif.ok    = i_ok;
endmodule

// ===== testbench/qer_props.sv
`timescale 1ns/1ps
`include "qer_cfg.svh"
module qer_props
(
  input wire logic                 i_ref_clk,
  input wire logic                 i_reset,
  input wire logic                 i_start,
  input wire qer_pkg::op_type      i_op,
  input wire logic [63:0]          i_argument_register,
  input wire logic                 o_busy_ff,
  input wire logic                 o_done_ff,
  input wire qer_pkg::exc_type     o_exc_ff,
  input wire logic [63:0]          o_status_result_register_ff,
  input wire logic                 o_mem_req_ff,
  input wire qer_pkg::mem_cmd_type o_mem_cmd_ff,
  input wire logic [63:0]          o_mem_addr_ff,
  input wire logic [63:0]          o_mem_wdata_ff,
  input wire logic                 o_mem_long_ff,
  input wire logic                 o_mem_probe_ff,
  input wire logic                 o_mem_barrier_ff,
  input wire logic                 i_mem_ack
);
  logic [4:0]      cs_cnt_ff;
  logic [63:0]     arg_ff;
  qer_pkg::op_type op_ff;
  // Operation class of the request now in flight.
  wire logic       take = i_start && !o_busy_ff;
  wire logic       is_long = op_ff inside {qer_pkg::op_long_abs, qer_pkg::op_long_abs_deferred};
  wire logic       is_tail = op_ff inside {qer_pkg::op_tail_locked,
                                           qer_pkg::op_tail_locked_resident};
  // Conditional stores are counted per operation so a runaway retry loop shows up.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || take)
      cs_cnt_ff <= 5'h0;
    else if (o_mem_req_ff && i_mem_ack && o_mem_cmd_ff == qer_pkg::mem_cond)
      cs_cnt_ff <= cs_cnt_ff + 5'h1;
    if (take)
    begin
      arg_ff <= i_argument_register;
      op_ff <= i_op;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_done_pulse: assert property (o_done_ff |=> !o_done_ff)
    else $error("done held longer than one cycle");
  a_min_latency: assert property (take |=> !o_done_ff ##1 !o_done_ff)
    else $error("done too soon after start");
  a_req_held: assert property (o_mem_req_ff && !i_mem_ack |=> o_mem_req_ff &&
    $stable(o_mem_addr_ff) && $stable(o_mem_cmd_ff) && $stable(o_mem_wdata_ff))
    else $error("request changed before ack");
  a_idle_quiet: assert property (!o_busy_ff |-> !o_mem_req_ff)
    else $error("memory request while idle");
  a_exc_at_done: assert property ($changed(o_exc_ff) |-> o_done_ff)
    else $error("exception changed outside done");
  a_result_at_done: assert property ($changed(o_status_result_register_ff) |=> o_done_ff)
    else $error("status not followed by done");
  a_status_code: assert property (o_done_ff && o_exc_ff == qer_pkg::exc_none |->
    (is_tail ? o_status_result_register_ff inside {`QER_ST_BUSY, 64'h0, 64'h1, 64'h2}
             : o_status_result_register_ff inside {`QER_AB_WAS_EMPTY, 64'h0, 64'h1}))
    else $error("status code out of range");
  a_lock_write: assert property (o_mem_req_ff && o_mem_cmd_ff == qer_pkg::mem_cond |->
    o_mem_wdata_ff[0] && o_mem_addr_ff == arg_ff)
    else $error("lock store lacks lock bit");
  a_retry_cap: assert property (cs_cnt_ff <= `QER_RETRY_INIT)
    else $error("too many lock stores");
  a_link_width: assert property (o_mem_req_ff && !o_mem_barrier_ff && !o_mem_probe_ff
    |-> o_mem_long_ff == is_long)
    else $error("link access width wrong");
  a_bad_header: assert property (take && i_op == qer_pkg::op_tail_locked &&
    i_argument_register[3:0] != 4'h0 |-> ##[3:8] (o_done_ff && o_exc_ff == qer_pkg::exc_illegal))
    else $error("misaligned header not refused");
  c_now_empty: cover property (o_done_ff && o_status_result_register_ff == `QER_ST_NOW_EMPTY);
  c_retry_out: cover property (cs_cnt_ff == `QER_RETRY_INIT);
  c_memmgt: cover property (o_done_ff && o_exc_ff == qer_pkg::exc_memmgt);
endmodule
bind queue_entry_remover qer_props props (.*);

// ===== testbench/qer_mem_model.sv
`timescale 1ns/1ps
module qer_mem_model
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_req,
  input  wire qer_pkg::mem_cmd_type i_cmd,
  input  wire logic [63:0]          i_addr,
  input  wire logic [63:0]          i_wdata,
  input  wire logic                 i_long,
  input  wire logic                 i_probe,
  input  wire logic                 i_barrier,
  output logic                      o_ack,
  output logic [63:0]               o_rdata,
  output logic                      o_ok
);
  logic [31:0] ram [logic [63:0]];
  logic [63:0] fault_addr = 64'h1;
  logic [31:0] w;
  int          fail_cs = 0;
  int          n_cs = 0;
  int          n_req = 0;
  int          n_probe = 0;
  int          wait_n = 0;
  function automatic logic [31:0] rd(logic [63:0] a);
    return ram.exists(a) ? ram[a] : 32'h0;
  endfunction
  function automatic logic [63:0] rq(logic [63:0] a);
    return {rd(a + 64'h4), rd(a)};
  endfunction
  task automatic wq(logic [63:0] a, logic [63:0] v);
    ram[a] = v[31:0];
    ram[a + 64'h4] = v[63:32];
  endtask
  initial
  begin
    o_ack = 1'b0;
    o_ok = 1'b0;
    o_rdata = 64'h0;
  end
  // Answers after 0 to 2 idle cycles; stale read data is inverted so it is not reused.
  always @(negedge i_ref_clk)
  begin
    if (o_ack)
    begin
      o_ack = 1'b0;
      o_rdata = ~o_rdata;
    end
    else if (i_req && wait_n < n_req % 3)
      wait_n++;
    else if (i_req)
    begin
      wait_n = 0;
      n_req++;
      o_ack = 1'b1;
      o_ok = 1'b1;
      w = rd(i_addr);
      o_rdata = i_long ? {{32{w[31]}}, w} : rq(i_addr);
      if (i_probe)
      begin
        n_probe++;
        o_ok = (i_addr != fault_addr);
      end
      else if (i_cmd == qer_pkg::mem_cond && !i_barrier)
      begin
        n_cs++;
        o_ok = (n_cs > fail_cs);
        if (o_ok)
          wq(i_addr, i_wdata);
      end
      else if (i_cmd == qer_pkg::mem_write && i_long)
        ram[i_addr] = i_wdata[31:0];
      else if (i_cmd == qer_pkg::mem_write)
        wq(i_addr, i_wdata);
    end
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "qer_cfg.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  logic                 i_ref_clk = 1'b0;
  logic                 i_reset = 1'b1;
  logic                 i_start = 1'b0;
  qer_pkg::op_type      i_op = qer_pkg::op_tail_locked;
  logic [63:0]          i_argument_register = 64'h0;
  logic                 i_mem_ack, i_mem_ok, o_busy_ff, o_done_ff, o_mem_req_ff;
  logic                 o_mem_long_ff, o_mem_probe_ff, o_mem_barrier_ff;
  logic [63:0]          i_mem_rdata, o_status_result_register_ff, o_entry_result_register_ff;
  logic [63:0]          o_mem_addr_ff, o_mem_wdata_ff;
  qer_pkg::exc_type     o_exc_ff;
  qer_pkg::mem_cmd_type o_mem_cmd_ff;
  int                   error_cnt = 0;
  int                   check_count = 0;
  logic [63:0]          h = 64'h1000, a = 64'h1100, b = 64'h1200;
  queue_entry_remover dut (.*);
  qer_mem_model mem (.i_ref_clk(i_ref_clk), .i_req(o_mem_req_ff), .i_cmd(o_mem_cmd_ff),
    .i_addr(o_mem_addr_ff), .i_wdata(o_mem_wdata_ff), .i_long(o_mem_long_ff),
    .i_probe(o_mem_probe_ff), .i_barrier(o_mem_barrier_ff), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata), .o_ok(i_mem_ok));
  initial
  begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic lk(logic [63:0] x, logic [63:0] f, logic [63:0] bk);
    mem.wq(x, f);
    mem.wq(x + 64'h8, bk);
  endtask
  // One operation; with bump, a start while busy must be ignored.
  task automatic run(qer_pkg::op_type op, logic [63:0] arg, qer_pkg::exc_type ex,
                     logic [63:0] s, logic [63:0] e, bit bump = 0);
    int n;
    @(negedge i_ref_clk);
    i_op = op;
    i_argument_register = arg;
    i_start = 1'b1;
    @(negedge i_ref_clk);
    i_start = 1'b0;
    if (bump)
    begin
      @(negedge i_ref_clk);
      i_op = qer_pkg::op_quad_abs;
      i_argument_register = 64'h1;
      i_start = 1'b1;
      @(negedge i_ref_clk);
      i_start = 1'b0;
    end
    n = 0;
    while (o_done_ff !== 1'b1 && n < 3000)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    `CHK("done", 1'b1, o_done_ff)
    `CHK("exception", ex, o_exc_ff)
    if (ex == qer_pkg::exc_none && s !== `QER_ST_BUSY)
      `CHK("entry", e, o_entry_result_register_ff)
    if (ex == qer_pkg::exc_none)
      `CHK("status", s, o_status_result_register_ff)
    repeat (bump ? 20 : 0)
    begin
      @(negedge i_ref_clk);
      `CHK("extra done", 1'b0, o_done_ff)
    end
  endtask
  task automatic t_tail();
    qer_pkg::op_type op;
    for (int k = 0; k < 2; k++)
    begin
      op = k ? qer_pkg::op_tail_locked_resident : qer_pkg::op_tail_locked;
      lk(h, 64'h0, 64'h0);
      run(op, h, qer_pkg::exc_none, `QER_ST_WAS_EMPTY, h);
      lk(h, a - h, b - h);
      lk(a, b - a, h - a);
      lk(b, h - b, a - b);
      run(op, h, qer_pkg::exc_none, `QER_ST_NOT_EMPTY, b, k);
      `CHK("head fwd", a - h, mem.rq(h))
      `CHK("head bwd", a - h, mem.rq(h + 64'h8))
      `CHK("pred fwd", h - a, mem.rq(a))
      run(op, h, qer_pkg::exc_none, `QER_ST_NOW_EMPTY, a);
      `CHK("empty fwd", 64'h0, mem.rq(h))
      `CHK("empty bwd", 64'h0, mem.rq(h + 64'h8))
    end
    $display("tail test done");
  endtask
  task automatic t_lock();
    lk(h, 64'h21, 64'h0);
    run(qer_pkg::op_tail_locked, h, qer_pkg::exc_none, `QER_ST_BUSY, 0);
    `CHK("held lock", 64'h21, mem.rq(h))
    for (int k = 20; k > 18; k--)
    begin
      lk(h, a - h, a - h);
      lk(a, h - a, h - a);
      mem.fail_cs = k;
      mem.n_cs = 0;
      run(qer_pkg::op_tail_locked, h, qer_pkg::exc_none,
          k == 20 ? `QER_ST_BUSY : `QER_ST_NOW_EMPTY, a);
      `CHK("attempts", 20, mem.n_cs)
      `CHK("lock word", k == 20 ? a - h : 64'h0, mem.rq(h))
    end
    mem.fail_cs = 0;
    $display("lock test done");
  endtask
  task automatic t_fault();
    int n;
    n = mem.n_req;
    run(qer_pkg::op_tail_locked, h + 64'h4, qer_pkg::exc_illegal, 0, 0);
    `CHK("requests", n, mem.n_req)
    for (int k = 0; k < 3; k++)
    begin
      lk(h, a - h, k == 0 ? 64'h18 : b - h);
      lk(a, b - a, h - a);
      lk(b, h - b, k == 1 ? a - b + 64'h8 : a - b);
      mem.fault_addr = k == 2 ? a : 64'h1;
      run(qer_pkg::op_tail_locked, h, k == 2 ? qer_pkg::exc_memmgt : qer_pkg::exc_illegal,
          0, 0);
      `CHK("released", a - h, mem.rq(h))
      `CHK("pred kept", b - a, mem.rq(a))
    end
    n = mem.n_probe;
    run(qer_pkg::op_tail_locked_resident, h, qer_pkg::exc_none, `QER_ST_NOT_EMPTY, b);
    `CHK("probes", n, mem.n_probe)
    mem.fault_addr = 64'h1;
    $display("fault test done");
  endtask
  task automatic t_long();
    logic [63:0] q, x, y;
    q = 64'hffff_ffff_8000_0100;
    x = q + 64'h10;
    y = q + 64'h20;
    mem.ram[q] = x[31:0];
    mem.ram[q + 64'h4] = y[31:0];
    mem.ram[x] = y[31:0];
    mem.ram[x + 64'h4] = q[31:0];
    mem.ram[y] = q[31:0];
    mem.ram[y + 64'h4] = x[31:0];
    mem.ram[64'h2000] = y[31:0];
    run(qer_pkg::op_long_abs, {32'h1234_5678, x[31:0]}, qer_pkg::exc_none,
        `QER_AB_NOT_EMPTY, x);
    `CHK("long fwd", y[31:0], mem.rd(q))
    `CHK("long bwd", q[31:0], mem.rd(y + 64'h4))
    run(qer_pkg::op_long_abs_deferred, 64'h2000, qer_pkg::exc_none,
        `QER_AB_NOW_EMPTY, y);
    `CHK("long self", {q[31:0], q[31:0]}, mem.rq(q))
    run(qer_pkg::op_long_abs, q, qer_pkg::exc_none, `QER_AB_WAS_EMPTY, q);
    $display("long test done");
  endtask
  task automatic t_quad();
    logic [63:0] q, x, y;
    q = 64'h3000;
    x = 64'h3100;
    y = 64'h3200;
    lk(q, x, y);
    lk(x, y, q);
    lk(y, q, x);
    mem.wq(64'h2010, y);
    run(qer_pkg::op_quad_abs, x, qer_pkg::exc_none, `QER_AB_NOT_EMPTY, x);
    `CHK("quad fwd", y, mem.rq(q))
    `CHK("quad bwd", q, mem.rq(y + 64'h8))
    run(qer_pkg::op_quad_abs_deferred, 64'h2010, qer_pkg::exc_none,
        `QER_AB_NOW_EMPTY, y);
    for (int k = 0; k < 4; k++)
    begin
      lk(x, k == 2 ? y + 64'h4 : y, k == 3 ? q + 64'h8 : q);
      run(k == 0 ? qer_pkg::op_quad_abs_deferred : qer_pkg::op_quad_abs,
          k == 0 ? 64'h2018 : (k == 1 ? x + 64'h4 : x), qer_pkg::exc_illegal, 0, 0);
    end
    $display("quad test done");
  endtask
  initial
  begin
    repeat (4) @(negedge i_ref_clk);
    i_reset = 1'b0;
    t_tail();
    t_lock();
    t_fault();
    t_long();
    t_quad();
    summarize();
  end
  // A few thousand cycles suffice; this cuts a hang short.
  initial
  begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule
